//--- logic/io_condition_ctrl.sv
// Camera I/O condition control: trigger, aux inputs, strobe, ready, registers
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "io_cond_cfg.svh"
module io_condition_ctrl (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    output logic irq_out,
    input wire logic aux_input_a_in,
    input wire logic aux_input_b_in,
    input wire logic ext_start_in,
    input wire logic sensor_start_in,
    input wire logic capture_done_in,
    input wire logic measure_done_in,
    input wire logic shutter_open_in,
    input wire logic ref_specified_in,
    input wire logic save_req_in,
    input wire logic op_screen_in,
    input wire logic single_camera_in,
    input wire logic key_up_in,
    input wire logic key_down_in,
    output logic ready_out,
    output logic meas_start_out,
    output logic ref_store_out,
    output logic ref_coord_store_out,
    output logic flash_write_out,
    output logic area_correct_out,
    output logic [1:0] ladder_in_out,
    output logic camera_sel_out,
    output logic [7:0] result_y_out,
    input wire logic [7:0] ladder_y_in,
    output logic link_out_en_out,
    output logic serial_out_en_out,
    output logic [4:0] type_num_out
);
    import io_cond_pkg::*;

    aux_sync_if aux ();
    logic [15:0] ctrl_q;
    logic [`IRQ_W-1:0] irq_stat_q;
    logic [`IRQ_W-1:0] irq_stat_d;
    logic [`IRQ_W-1:0] irq_en_q;
    logic [7:0] err_q;
    logic [15:0] rdata_q;
    meas_state_type state_q;
    meas_state_type state_d;
    logic ready_q;
    logic cam_q;
    logic ref_valid_q;
    logic [4:0] type_q;
    logic [7:0] y_q;
    logic [7:0] y_d;
    logic start_pin_q;
    logic start_pin_d;
    logic key_up_q;
    logic key_dn_q;

    aux_sync #(.WIDTH(2)) u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .pins_in({aux_input_b_in, aux_input_a_in}),
        .sync_out(aux)
    );

    // Decoded configuration fields
    wire trigger_source_select = ctrl_q[`F_TRIG];
    result_output_type result_output_select;
    aux_a_mode_type mode_a;
    aux_b_mode_type mode_b;
    sampl_type start_sampling_option;
    assign result_output_select = result_output_type'(ctrl_q[`F_OUT_HI:`F_OUT_LO]);
    assign mode_a = aux_a_mode_type'(ctrl_q[`F_AUXA_HI:`F_AUXA_LO]);
    assign mode_b = aux_b_mode_type'(ctrl_q[`F_AUXB_HI:`F_AUXB_LO]);
    assign start_sampling_option = sampl_type'(ctrl_q[`F_SAMPL_HI:`F_SAMPL_LO]);
    wire manual_type_change = ctrl_q[`F_MANUAL];
    wire strobe_en = ctrl_q[`F_STRB_EN];
    wire [2:0] strobe_line = ctrl_q[`F_STRB_HI:`F_STRB_LO];
    wire ready_at_capture = ctrl_q[`F_READY];
    wire edge_detect = ctrl_q[`F_EDGE];

    // Start source: external pins when set, else sensor trigger
    assign start_pin_d = trigger_source_select ? ext_start_in : sensor_start_in;
    wire start_rise = start_pin_d & ~start_pin_q;
    wire start_take = start_rise & ready_q;

    // Sensor trigger with serial sampling takes type from serial only
    wire keys_allowed = manual_type_change
        & ~(~trigger_source_select & (start_sampling_option == S_SERIAL));
    // Controller link output needs parallel sampling under sensor trigger
    wire link_allowed = trigger_source_select | (start_sampling_option == S_PARALLEL);

    wire ref_event = (mode_a == A_REF) & aux.rise_a;
    wire ref_ok = ref_event & ref_specified_in;
    wire ref_err = ref_event & ~ref_specified_in;
    wire cmp_event = (mode_a == A_CMP) & aux.rise_a & op_screen_in & ref_valid_q;
    wire save_event = save_req_in & ref_valid_q;
    wire toggle_event = (mode_b == B_TOGGLE) & aux.rise_b & single_camera_in;

    // Measurement sequence: idle, capture, measure
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (start_take) state_d = ST_CAPTURE;
            ST_CAPTURE: if (capture_done_in) state_d = ST_MEASURE;
            // Ready at capture end lets the next start overlap measuring
            ST_MEASURE:
                if (start_take)
                    state_d = ST_CAPTURE;
                else if (measure_done_in)
                    state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // Sticky events; a fresh event beats a clear in the same cycle
    assign irq_stat_d = {save_event | cmp_event, ref_err, toggle_event, cmp_event, ref_ok};
    wire bus_clr = wr_in & (addr_in == `ADDR_IRQ_CLR);

    // Register writes and event flags
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            ctrl_q <= `CTRL_RESET;
            irq_en_q <= '0;
            irq_stat_q <= '0;
            err_q <= '0;
        end
        else
        begin
            if (wr_in && addr_in == `ADDR_CTRL)
                ctrl_q <= wdata_in;
            if (wr_in && addr_in == `ADDR_IRQ_EN)
                irq_en_q <= wdata_in[`IRQ_W-1:0];
            irq_stat_q <= (irq_stat_q & ~(bus_clr ? wdata_in[`IRQ_W-1:0] : '0)) | irq_stat_d;
            if (ref_err)
                err_q <= `REF_ERR_CODE;
            else if (bus_clr && wdata_in[`IRQ_ERR])
                err_q <= '0;
        end
    end

    // Read mux, data valid the cycle after the strobe
    wire [15:0] status_word = {8'h00, type_q, cam_q, ref_valid_q, ready_q};
    wire [15:0] rd_mux =
        (addr_in == `ADDR_CTRL) ? ctrl_q :
        (addr_in == `ADDR_STATUS) ? status_word :
        (addr_in == `ADDR_IRQ_STAT) ? {11'h000, irq_stat_q} :
        (addr_in == `ADDR_IRQ_EN) ? {11'h000, irq_en_q} :
        (addr_in == `ADDR_ERR) ? {8'h00, err_q} : 16'h0000;

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            rdata_q <= '0;
        else
            rdata_q <= rd_in ? rd_mux : 16'h0000;
    end

    // Sequencer, camera choice, reference state and pulses
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            state_q <= ST_IDLE;
            ready_q <= 1'b0;
            cam_q <= 1'b0;
            ref_valid_q <= 1'b0;
            start_pin_q <= 1'b0;
            meas_start_out <= 1'b0;
            ref_store_out <= 1'b0;
            ref_coord_store_out <= 1'b0;
            flash_write_out <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            start_pin_q <= start_pin_d;
            // Ready drops on start, returns at the chosen end
            if (start_take)
                ready_q <= 1'b0;
            else if (state_q == ST_IDLE)
                ready_q <= 1'b1;
            else if (state_q == ST_CAPTURE && capture_done_in && ready_at_capture)
                ready_q <= 1'b1;
            else if (state_q == ST_MEASURE && measure_done_in)
                ready_q <= 1'b1;
            meas_start_out <= start_take;
            if (start_take && mode_b == B_LEVEL)
                cam_q <= aux.level_b;
            else if (toggle_event)
                cam_q <= ~cam_q;
            if (ref_ok)
                ref_valid_q <= 1'b1;
            ref_store_out <= ref_ok;
            ref_coord_store_out <= ref_ok & edge_detect;
            flash_write_out <= save_event | cmp_event;
        end
    end

    // Type number via keys, wrapping over the 32 types
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            type_q <= '0;
            key_up_q <= 1'b0;
            key_dn_q <= 1'b0;
        end
        else
        begin
            key_up_q <= key_up_in;
            key_dn_q <= key_down_in;
            if (keys_allowed && op_screen_in && key_up_in && !key_up_q)
                type_q <= type_q + 5'h01;
            else if (keys_allowed && op_screen_in && key_down_in && !key_dn_q)
                type_q <= type_q - 5'h01;
        end
    end

    // Result lines: ladder drives all, strobe overrides one chosen line
    generate
        for (genvar j = 0; j < 8; j++)
        begin : g_result
            assign y_d[j] = (strobe_en && strobe_line == 3'(j)) ? shutter_open_in : ladder_y_in[j];
        end
    endgenerate

    // Registered, so the strobe line lags the shutter by one cycle
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            y_q <= '0;
        else
            y_q <= y_d;
    end

    assign rdata_out = rdata_q;
    assign irq_out = |(irq_stat_q & irq_en_q);
    assign ready_out = ready_q;
    assign camera_sel_out = cam_q;
    assign type_num_out = type_q;
    assign result_y_out = y_q;
    assign area_correct_out = (mode_a == A_AREA) & aux.level_a;
    // Ladder sees a level only in ladder input mode
    assign ladder_in_out = {(mode_b == B_LADDER) & aux.level_b, (mode_a == A_LADDER) & aux.level_a};
    assign link_out_en_out = (result_output_select == OUT_LINK) & link_allowed;
    assign serial_out_en_out = (result_output_select == OUT_SERIAL);

    property p_start_needs_ready;
        @(posedge clk_in) disable iff (!rstn_in) meas_start_out |-> $past(ready_q);
    endproperty
    a_start_needs_ready: assert property (p_start_needs_ready) else $error("start taken without ready");

    property p_ready_drops;
        @(posedge clk_in) disable iff (!rstn_in) start_take |=> !ready_q;
    endproperty
    a_ready_drops: assert property (p_ready_drops) else $error("ready stayed high after start");

    property p_ref_err;
        @(posedge clk_in) disable iff (!rstn_in) ref_err |=> err_q == `REF_ERR_CODE && irq_stat_q[`IRQ_ERR];
    endproperty
    a_ref_err: assert property (p_ref_err) else $error("reference error not raised");

    property p_ref_no_flash;
        @(posedge clk_in) disable iff (!rstn_in) ref_ok && !save_req_in && !cmp_event |=> !flash_write_out;
    endproperty
    a_ref_no_flash: assert property (p_ref_no_flash) else $error("flash written on input edge");

    property p_toggle;
        @(posedge clk_in) disable iff (!rstn_in) toggle_event && !start_take |=> cam_q != $past(cam_q);
    endproperty
    a_toggle: assert property (p_toggle) else $error("camera did not toggle");

    property p_level_sel;
        @(posedge clk_in) disable iff (!rstn_in) start_take && mode_b == B_LEVEL |=> cam_q == $past(aux.level_b);
    endproperty
    a_level_sel: assert property (p_level_sel) else $error("camera level select wrong");

    property p_strobe;
        @(posedge clk_in) disable iff (!rstn_in)
            strobe_en |=> result_y_out[$past(strobe_line)] == $past(shutter_open_in);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe line wrong");

    property p_ref_store;
        @(posedge clk_in) disable iff (!rstn_in) ref_ok |=> ref_store_out && ref_valid_q;
    endproperty
    a_ref_store: assert property (p_ref_store) else $error("reference not stored");

    property p_ready_back;
        @(posedge clk_in) disable iff (!rstn_in) state_q == ST_MEASURE && measure_done_in && !start_take |=> ready_q;
    endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready not back after measurement");

    property p_flash_cause;
        @(posedge clk_in) disable iff (!rstn_in) flash_write_out |-> $past(save_req_in) || $past(aux.rise_a);
    endproperty
    a_flash_cause: assert property (p_flash_cause) else $error("flash written without save or compare");
endmodule // io_condition_ctrl

//--- logic/io_cond_cfg.svh
// Constants for the camera I/O condition block
// Operation
// - External trigger source: accept start from outside equipment, not sensor trigger.
// - Result output select offers none, controller link, or serial port.
// - Manual type change is either forbidden or allowed with up/down keys.
// - Reference mode: rising aux_input_a stores reference image, coordinates if edge mode.
// - Reference image goes to flash only on save key, serial command or compare-mode aux_input_a.
// - Reference registration without a specified image raises error code 3e.
// - Compare mode: aux_input_a on operation screen moves reference into flash.
// - Area correction mode: limits corrected while aux_input_a is on.
// - Ladder input mode passes auxiliary input level to the ladder logic.
// - Camera toggle: rising aux_input_b switches camera, only for single-camera types.
// - Level select: aux_input_b sampled at start picks camera one or two.
// - Strobe line chosen from eight outputs is on while shutter is open.
// - Ready asserts at capture end or measurement end per ready timing setting.
// - Sensor trigger source: type change and output choices follow sampling option.
// - Start is accepted only while ready; controller waits for ready.
`ifndef IO_COND_CFG_SVH
`define IO_COND_CFG_SVH
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_IRQ_STAT 4'h2
`define ADDR_IRQ_CLR 4'h3
`define ADDR_IRQ_EN 4'h4
`define ADDR_ERR 4'h5
`define CTRL_RESET 16'h0000
`define REF_ERR_CODE 8'h3e
`define F_TRIG 0
`define F_OUT_LO 1
`define F_OUT_HI 2
`define F_MANUAL 3
`define F_AUXA_LO 4
`define F_AUXA_HI 5
`define F_AUXB_LO 6
`define F_AUXB_HI 7
`define F_STRB_EN 8
`define F_STRB_LO 9
`define F_STRB_HI 11
`define F_READY 12
`define F_SAMPL_LO 13
`define F_SAMPL_HI 14
`define F_EDGE 15
`define IRQ_REF 0
`define IRQ_CMP 1
`define IRQ_TOGGLE 2
`define IRQ_ERR 3
`define IRQ_FLASH 4
`define IRQ_W 5
`endif

//--- logic/io_cond_pkg.sv
// Types for the camera I/O condition block
package io_cond_pkg;
    typedef enum logic [1:0] {OUT_NONE = 2'b00, OUT_LINK = 2'b01, OUT_SERIAL = 2'b10} result_output_type;
    typedef enum logic [1:0] {A_LADDER = 2'b00, A_REF = 2'b01, A_CMP = 2'b10, A_AREA = 2'b11} aux_a_mode_type;
    typedef enum logic [1:0] {B_LADDER = 2'b00, B_TOGGLE = 2'b01, B_LEVEL = 2'b10} aux_b_mode_type;
    typedef enum logic [1:0] {S_PARALLEL = 2'b00, S_SERIAL = 2'b01, S_AUTO = 2'b10} sampl_type;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CAPTURE = 2'b01, ST_MEASURE = 2'b10} meas_state_type;
endpackage

//--- logic/aux_sync_if.sv
// Synchronised auxiliary inputs with edge events
`timescale 1ns/10ps
interface aux_sync_if;
    logic level_a;
    logic level_b;
    logic rise_a;
    logic rise_b;
    modport src (output level_a, output level_b, output rise_a, output rise_b);
    modport dst (input level_a, input level_b, input rise_a, input rise_b);
endinterface

//--- logic/aux_sync.sv
// Three-stage synchroniser and rising-edge detector for the two auxiliary inputs
`timescale 1ns/10ps
module aux_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [WIDTH-1:0] pins_in,
    aux_sync_if.src sync_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] lvl_q;
    logic [WIDTH-1:0] lvl_d;
    logic [WIDTH-1:0] rise_q;
    genvar i;

    // Level moves only once stages two and three agree
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            assign lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
        end
    endgenerate

    // First stage feeds only the second
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
            rise_q <= '0;
        end
        else
        begin
            s1_q <= pins_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
            rise_q <= lvl_d & ~lvl_q;
        end
    end

    assign sync_out.level_a = lvl_q[0];
    assign sync_out.level_b = lvl_q[1];
    assign sync_out.rise_a = rise_q[0];
    assign sync_out.rise_b = rise_q[1];

    property p_rise_once;
        @(posedge clk_in) disable iff (!rstn_in) rise_q[0] |=> !rise_q[0];
    endproperty
    a_rise_once: assert property (p_rise_once) else $error("aux event longer than one cycle");
endmodule // aux_sync

//--- tb/ctrl_partner.sv
// Controller-side model: triggers on ready, answers with capture and measure done
`timescale 1ns/10ps
module ctrl_partner (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic go_in,
    input wire logic slow_in,
    input wire logic ready_in,
    input wire logic meas_start_in,
    output logic start_out,
    output logic capture_done_out,
    output logic measure_done_out
);
    int cnt_q;
    int gap;
    assign gap = slow_in ? 12 : 3;
    // Start waits for ready and drops once taken; done pulses keep capture before measure
    always @(posedge clk_in)
    begin
        capture_done_out <= 1'b0;
        measure_done_out <= 1'b0;
        if (!rstn_in)
        begin
            start_out <= 1'b0;
            cnt_q <= 0;
        end
        else if (meas_start_in)
        begin
            start_out <= 1'b0;
            cnt_q <= 1;
        end
        else if (cnt_q != 0)
        begin
            cnt_q <= (cnt_q == 2 * gap) ? 0 : cnt_q + 1;
            capture_done_out <= (cnt_q == gap);
            measure_done_out <= (cnt_q == 2 * gap);
        end
        else if (go_in && ready_in && !start_out)
            start_out <= 1'b1;
    end
endmodule // ctrl_partner

//--- tb/tb_io_condition_ctrl.sv
// Self-checking bench for the camera I/O condition block
`timescale 1ns/10ps
module tb_io_condition_ctrl;
    import io_cond_pkg::*;
    logic clk_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, aux_a = 0, aux_b = 0, go = 0, slow = 0;
    logic [3:0] addr_in = 0;
    logic [15:0] wdata_in = 0, rdata_out;
    logic sensor_start_in = 0, shutter_open_in = 0, ref_specified_in = 0, save_req_in = 0;
    logic op_screen_in = 0, single_camera_in = 0, key_up_in = 0, key_down_in = 0;
    logic ext_start, cap_done, meas_done, irq_out, ready_out, meas_start_out, ref_store_out;
    logic ref_coord_store_out, flash_write_out, area_correct_out, camera_sel_out, link_en, ser_en;
    logic [1:0] ladder_in_out;
    logic [7:0] result_y_out;
    logic [7:0] ladder_y = 8'h00;
    logic [4:0] type_num_out;
    int fails = 0, n_tests = 0, n_meas = 0, n_ref = 0, n_coord = 0, n_flash = 0, cyc = 0;

    io_condition_ctrl i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .aux_input_a_in(aux_a),
        .aux_input_b_in(aux_b), .ext_start_in(ext_start), .sensor_start_in(sensor_start_in),
        .capture_done_in(cap_done), .measure_done_in(meas_done), .shutter_open_in(shutter_open_in),
        .ref_specified_in(ref_specified_in), .save_req_in(save_req_in), .op_screen_in(op_screen_in),
        .single_camera_in(single_camera_in), .key_up_in(key_up_in), .key_down_in(key_down_in),
        .ready_out(ready_out), .meas_start_out(meas_start_out), .ref_store_out(ref_store_out),
        .ref_coord_store_out(ref_coord_store_out), .flash_write_out(flash_write_out),
        .area_correct_out(area_correct_out), .ladder_in_out(ladder_in_out), .camera_sel_out(camera_sel_out),
        .result_y_out(result_y_out), .ladder_y_in(ladder_y), .link_out_en_out(link_en),
        .serial_out_en_out(ser_en), .type_num_out(type_num_out));

    ctrl_partner i_partner (.clk_in(clk_in), .rstn_in(rstn_in), .go_in(go), .slow_in(slow),
        .ready_in(ready_out), .meas_start_in(meas_start_out), .start_out(ext_start),
        .capture_done_out(cap_done), .measure_done_out(meas_done));

    // Clock at 100 MHz
    initial
    begin
        forever #5 clk_in = ~clk_in;
    end

    // Pulse counters and a hang limit
    always @(posedge clk_in)
    begin
        n_meas += (meas_start_out === 1'b1);
        n_ref += (ref_store_out === 1'b1);
        n_coord += (ref_coord_store_out === 1'b1);
        n_flash += (flash_write_out === 1'b1);
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Lets edges pass, then settles past the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        step(1);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        step(3);
        rstn_in <= 1'b1;
        step(2);
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0001);
        rd(4'h6, 16'h0000);
        for (int i = 0; i < 3; i++)
        begin
            wr(4'h0, 16'(i * 2 + 1));
            chk({link_en, ser_en}, {i == 1, i == 2});
        end
        wr(4'h0, 16'h0001);
        // Sensor edge must be ignored while the external source is chosen
        sensor_start_in <= 1'b1;
        step(1);
        sensor_start_in <= 1'b0;
        step(3);
        chk(n_meas, 0);
        go <= 1'b1;
        step(1);
        go <= 1'b0;
        step(5);
        chk(n_meas, 1);
        chk(ready_out, 0);
        step(12);
        chk(ready_out, 1);
        wr(4'h0, 16'h1001);
        slow <= 1'b1;
        go <= 1'b1;
        step(1);
        go <= 1'b0;
        step(20);
        chk({n_meas[7:0], ready_out}, {8'h02, 1'b1});
        // Slow gap kept until the partner has sent measure done
        step(12);
        slow <= 1'b0;
        wr(4'h0, 16'h0080);
        for (int i = 1; i >= 0; i--)
        begin
            aux_b <= 1'(i);
            step(8);
            sensor_start_in <= 1'b1;
            step(1);
            sensor_start_in <= 1'b0;
            step(12);
            chk(camera_sel_out, 16'(i));
        end
        // A level change between starts must not move the camera
        aux_b <= 1'b1;
        step(8);
        chk(camera_sel_out, 0);
        aux_b <= 1'b0;
        step(8);
        wr(4'h0, 16'h0040);
        single_camera_in <= 1'b1;
        aux_b <= 1'b1;
        step(8);
        chk(camera_sel_out, 1);
        aux_b <= 1'b0;
        single_camera_in <= 1'b0;
        step(8);
        aux_b <= 1'b1;
        step(8);
        chk(camera_sel_out, 1);
        aux_b <= 1'b0;
        wr(4'h0, 16'h0010);
        wr(4'h4, 16'h0008);
        aux_a <= 1'b1;
        step(8);
        rd(4'h5, 16'h003e);
        rd(4'h2, 16'h000c);
        chk({irq_out, n_ref[3:0]}, 5'h10);
        wr(4'h3, 16'h0008);
        rd(4'h5, 16'h0000);
        chk(irq_out, 0);
        aux_a <= 1'b0;
        ref_specified_in <= 1'b1;
        wr(4'h0, 16'h8010);
        aux_a <= 1'b1;
        step(8);
        chk({n_ref[3:0], n_coord[3:0]}, 8'h11);
        chk(n_flash, 0);
        save_req_in <= 1'b1;
        step(1);
        save_req_in <= 1'b0;
        step(3);
        chk(n_flash, 1);
        aux_a <= 1'b0;
        op_screen_in <= 1'b1;
        wr(4'h0, 16'h0020);
        aux_a <= 1'b1;
        step(8);
        chk(n_flash, 2);
        wr(4'h0, 16'h0030);
        step(2);
        chk(area_correct_out, 1);
        aux_a <= 1'b0;
        step(8);
        chk(area_correct_out, 0);
        wr(4'h0, 16'h0000);
        aux_a <= 1'b1;
        step(8);
        chk(ladder_in_out, 2'b01);
        aux_a <= 1'b0;
        aux_b <= 1'b1;
        step(8);
        chk(ladder_in_out, 2'b10);
        // Ladder levels pass on the other lines while line 5 carries the strobe
        ladder_y <= 8'h81;
        wr(4'h0, 16'h0b00);
        shutter_open_in <= 1'b1; // exposure kept far shorter than a real one
        step(2);
        chk(result_y_out, 8'ha1);
        shutter_open_in <= 1'b0;
        step(2);
        chk(result_y_out, 8'h81);
        for (int i = 0; i < 4; i++)
        begin
            wr(4'h0, i[0] ? 16'h0000 : (i[1] ? 16'h2008 : 16'h0008));
            key_up_in <= 1'b1;
            step(3);
            key_up_in <= 1'b0;
            step(2);
            chk(type_num_out, 1);
        end
        wr(4'h0, 16'h0008);
        key_down_in <= 1'b1;
        step(3);
        key_down_in <= 1'b0;
        step(2);
        chk(type_num_out, 0);
        wr(4'h0, 16'h2002);
        chk(link_en, 0);
        end_of_test();
    end
endmodule // tb_io_condition_ctrl
